// file: fia_chk.sv
// Port checker for the flash programming access block
`timescale 1ns/100ps
`default_nettype none
module fia_chk (
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic BOOT_OPTION_I,
	input wire logic FETCH_FROM_BOOT_I,
	input wire logic SERIAL_CMD_I,
	input wire logic BOOT_FROM_ROM_O,
	input wire logic [15:0] RESET_VECTOR_O,
	input wire logic FETCH_BLOCKED_O,
	input wire logic SERIAL_MONITOR_O,
	input wire logic [15:0] FLASH_ADDR_O,
	input wire logic [7:0] FLASH_WDATA_O,
	input wire logic FLASH_READ_O,
	input wire logic FLASH_PROG_O,
	input wire logic FLASH_PAGE_ERASE_O,
	input wire logic FLASH_MASS_ERASE_O
);
	// ----------------------------------------
	// Boot strap, serial watch and flash strobes
	// ----------------------------------------
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RESET_I);
	// First edge after release is where the strap is taken
	sequence s_release;
		$fell(RESET_I);
	endsequence
	sequence s_run;
		!$fell(RESET_I);
	endsequence
	boot_strap_a: assert property (s_release |=> BOOT_FROM_ROM_O == !$past(BOOT_OPTION_I))
		else $error("boot source differs from strap");
	strap_hold_a: assert property (s_run |=> $stable(BOOT_FROM_ROM_O))
		else $error("boot source moved without reset");
	vector_a: assert property (RESET_VECTOR_O == 16'h0000)
		else $error("reset vector not zero");
	serial_watch_a: assert property (s_run |-> SERIAL_MONITOR_O == (BOOT_FROM_ROM_O && SERIAL_CMD_I))
		else $error("serial watch wrong");
	fetch_block_a: assert property ((FLASH_PROG_O || FLASH_PAGE_ERASE_O || FLASH_MASS_ERASE_O)
		&& !FETCH_FROM_BOOT_I |-> FETCH_BLOCKED_O)
		else $error("flash fetch not blocked");
	// End of a write or erase pulse
	sequence s_op_end;
		$fell(FLASH_PROG_O || FLASH_PAGE_ERASE_O || FLASH_MASS_ERASE_O);
	endsequence
	block_end_a: assert property (s_op_end |-> ##[1:2] !FETCH_BLOCKED_O)
		else $error("fetch block outlasts operation");
	option_map_a: assert property (FLASH_READ_O |-> FLASH_ADDR_O != 16'hFFFF)
		else $error("option alias reached array");
	read_pulse_a: assert property (FLASH_READ_O |=> !FLASH_READ_O)
		else $error("read strobe too long");
	prog_hold_a: assert property (FLASH_PROG_O && $past(FLASH_PROG_O)
		|-> $stable(FLASH_WDATA_O) && $stable(FLASH_ADDR_O))
		else $error("program data moved");
	one_op_a: assert property ($onehot0({FLASH_READ_O, FLASH_PROG_O, FLASH_PAGE_ERASE_O,
		FLASH_MASS_ERASE_O}))
		else $error("two flash operations at once");
endmodule
bind fia_core fia_chk u_chk (.CLK_I, .RESET_I, .BOOT_OPTION_I, .FETCH_FROM_BOOT_I,
	.SERIAL_CMD_I, .BOOT_FROM_ROM_O, .RESET_VECTOR_O, .FETCH_BLOCKED_O, .SERIAL_MONITOR_O,
	.FLASH_ADDR_O, .FLASH_WDATA_O, .FLASH_READ_O, .FLASH_PROG_O, .FLASH_PAGE_ERASE_O,
	.FLASH_MASS_ERASE_O);
`default_nettype wire

// file: fia_core.v
// Flash in-system programming access control with AHB-Lite register slave
//
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`include "fia_defines.vh"
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Erased boot option starts from boot ROM
// - Boot option one starts flash at 0000
// - Boot ROM is 1K bytes
// - Boot ROM routine watches serial port
// - 16-bit address split high and low bytes
// - Option read FFFF maps to 7FFF
// - Address bytes reset to 00
// - Registers writable from flash or boot ROM
// - Read byte holds last read result
// - Write byte supplies programmed data
// - Timing value sets write/erase pulse width
// - Timing resets to 10 MHz encoding
// - Control register hidden from user firmware
module fia_core #(
	parameter PULSE_UNIT = 16
) (
	input wire CLK_I,
	input wire RESET_I,
	input wire HSEL_I,
	input wire [31:0] HADDR_I,
	input wire [1:0] HTRANS_I,
	input wire HWRITE_I,
	input wire [2:0] HSIZE_I,
	input wire [31:0] HWDATA_I,
	input wire HREADY_I,
	output reg [31:0] HRDATA_O,
	output wire HREADYOUT_O,
	output wire HRESP_O,
	input wire BOOT_OPTION_I,
	input wire FETCH_FROM_BOOT_I,
	input wire SERIAL_CMD_I,
	output reg BOOT_FROM_ROM_O,
	output wire [15:0] RESET_VECTOR_O,
	output wire FETCH_BLOCKED_O,
	output wire SERIAL_MONITOR_O,
	output reg [15:0] FLASH_ADDR_O,
	output reg [7:0] FLASH_WDATA_O,
	input wire [7:0] FLASH_RDATA_I,
	output reg FLASH_READ_O,
	output wire FLASH_PROG_O,
	output wire FLASH_PAGE_ERASE_O,
	output wire FLASH_MASS_ERASE_O
);
	// Sequencer states
	localparam ST_IDLE = 2'b00;
	localparam ST_READ = 2'b01;
	localparam ST_PULSE = 2'b10;
	// Array operation held for the whole pulse
	localparam OP_PROG = 2'b00;
	localparam OP_PAGE = 2'b01;
	localparam OP_MASS = 2'b10;

	// ----------------------------------------
	// Bus timing and refusal
	// ----------------------------------------
	// The slave never stretches a transfer: hreadyout stays high.
	// Every response is OKAY, refused writes included.
	// A write lands at the edge that closes its data phase.
	// Read data is registered at the address-phase edge.
	// It stands through the data phase and until the next read.
	// Writes and commands that arrive while busy are dropped silently.
	// That keeps address, data and timing stable for the array.
	// A read command fills the read register one cycle after its strobe.
	// Firmware can therefore poll busy and then read the byte.
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [7:0] prog_addr_high_byte;
	reg [7:0] prog_addr_low_byte;
	reg [7:0] prog_read_byte;
	reg [7:0] prog_write_byte;
	reg [6:0] prog_pulse_timing;
	reg [1:0] state;
	reg [1:0] op;
	reg [31:0] status_word;
	wire [15:0] rom_size;
	wire busy;
	reg strap_done;
	reg ph_write;
	reg ph_valid;
	reg [7:0] ph_addr;
	wire pulse_active;
	wire pulse_done;
	reg pulse_start;
	wire [15:0] prog_addr;
	wire bus_write;
	wire [7:0] wb;

	// Option byte alias: software addresses FFFF, the array holds it at 7FFF
	function [15:0] map_addr;
		input [15:0] a;
		begin
			if (a == `FIA_OPTION_ALIAS)
				map_addr = `FIA_OPTION_PHYS;
			else
				map_addr = a;
		end
	endfunction

	assign prog_addr = {prog_addr_high_byte, prog_addr_low_byte};
	assign wb = HWDATA_I[7:0];
	assign bus_write = ph_valid && ph_write;
	assign HREADYOUT_O = 1'b1;
	assign HRESP_O = 1'b0;
	// Busy covers the read cycle as well as the whole pulse
	assign busy = (state != ST_IDLE);

	// ----------------------------------------
	// Boot source selection
	// ----------------------------------------
	// Strap is caught by a clocked process after reset release, never in the reset branch
	// A strap that moves later is ignored until the next reset, so a
	// half-programmed option bit cannot move execution mid-run
	always @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			BOOT_FROM_ROM_O <= 1'b1;
			strap_done <= 1'b0;
		end else if (!strap_done) begin
			strap_done <= 1'b1;
			BOOT_FROM_ROM_O <= !BOOT_OPTION_I;
		end
	end
	assign RESET_VECTOR_O = `FIA_RESET_VECTOR;
	// Boot ROM firmware listens on the serial port only in ROM boot mode
	assign SERIAL_MONITOR_O = BOOT_FROM_ROM_O && strap_done && SERIAL_CMD_I;
	// Flash fetches stall while the array is busy; the ROM keeps running
	// Reads stall flash fetches too, which costs only one cycle
	assign FETCH_BLOCKED_O = busy && !FETCH_FROM_BOOT_I;

	// ----------------------------------------
	// AHB-Lite address phase capture
	// ----------------------------------------
	// Only the low address byte decodes, so the map repeats every 256 bytes
	always @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			ph_valid <= 1'b0;
			ph_write <= 1'b0;
			ph_addr <= 8'h00;
		end else if (HREADY_I) begin
			ph_valid <= HSEL_I && HTRANS_I[1];
			ph_write <= HWRITE_I;
			ph_addr <= HADDR_I[7:0];
		end
	end

	// ----------------------------------------
	// Boot ROM size and status word
	// ----------------------------------------
	// The size is fixed; software reads it from the status word so that
	// a ROM image builder can check that its routine fits
	assign rom_size = `FIA_BOOT_ROM_BYTES;
	// Unused status bits read as zero
	always @* begin
		status_word = 32'h00000000;
		status_word[`FIA_ST_BUSY] = busy;
		status_word[`FIA_ST_BOOT_ROM] = BOOT_FROM_ROM_O;
		status_word[`FIA_ST_FETCH_BLOCKED] = FETCH_BLOCKED_O;
		status_word[`FIA_ST_ROM_SIZE +: 16] = rom_size;
	end

	// ----------------------------------------
	// Register writes, from flash or boot ROM alike
	// ----------------------------------------
	// Writes during an operation are dropped so the array sees stable values
	// Bit 7 of the timing value is read-only, so only bits 6 to 0 are stored
	always @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			prog_addr_high_byte <= `FIA_RST_ADDR;
			prog_addr_low_byte <= `FIA_RST_ADDR;
			prog_write_byte <= 8'h00;
			prog_pulse_timing <= `FIA_RST_PULSE_TIMING;
		end else if (bus_write && state == ST_IDLE) begin
			case (ph_addr)
			`FIA_OFS_ADDR_HIGH: prog_addr_high_byte <= wb;
			`FIA_OFS_ADDR_LOW: prog_addr_low_byte <= wb;
			`FIA_OFS_WRITE_BYTE: prog_write_byte <= wb;
			`FIA_OFS_PULSE_TIMING: prog_pulse_timing <= wb[6:0];
			default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Operation sequencer
	// ----------------------------------------
	// Command register is a write-only trigger; the internal control state is not mapped
	always @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			state <= ST_IDLE;
			op <= OP_PROG;
			pulse_start <= 1'b0;
			FLASH_READ_O <= 1'b0;
			FLASH_ADDR_O <= 16'h0000;
			FLASH_WDATA_O <= 8'h00;
			prog_read_byte <= 8'h00;
		end else begin
			pulse_start <= 1'b0;
			FLASH_READ_O <= 1'b0;
			case (state)
			ST_IDLE: begin
				// Address and data are latched once; later writes cannot reach the array
				if (bus_write && ph_addr == `FIA_OFS_COMMAND) begin
					FLASH_ADDR_O <= map_addr(prog_addr);
					FLASH_WDATA_O <= prog_write_byte;
					if (wb[`FIA_CMD_READ]) begin
						FLASH_READ_O <= 1'b1;
						state <= ST_READ;
					end else if (wb[`FIA_CMD_MASS_ERASE]) begin
						op <= OP_MASS;
						pulse_start <= 1'b1;
						state <= ST_PULSE;
					end else if (wb[`FIA_CMD_PAGE_ERASE]) begin
						op <= OP_PAGE;
						pulse_start <= 1'b1;
						state <= ST_PULSE;
					end else if (wb[`FIA_CMD_WRITE]) begin
						op <= OP_PROG;
						pulse_start <= 1'b1;
						state <= ST_PULSE;
					end
				end
			end
			ST_READ: begin
				// Array data is valid in this cycle, while the read strobe stands
				prog_read_byte <= FLASH_RDATA_I;
				state <= ST_IDLE;
			end
			ST_PULSE: begin
				// Busy until the timer reports the end of the pulse
				if (pulse_done)
					state <= ST_IDLE;
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// Pulse width follows the timing register loaded beforehand
	// Start is a one-cycle pulse; a zero timing value still gives one unit
	fia_pulse_timer #(
		.UNIT(PULSE_UNIT)
	) u_timer (
		.clk_i(CLK_I),
		.reset_i(RESET_I),
		.start_i(pulse_start),
		.timing_i(prog_pulse_timing),
		.active_o(pulse_active),
		.done_o(pulse_done)
	);

	// ----------------------------------------
	// Array strobes
	// ----------------------------------------
	// Only one strobe stands at a time, as op is fixed while the timer runs
	assign FLASH_PROG_O = pulse_active && op == OP_PROG;
	assign FLASH_PAGE_ERASE_O = pulse_active && op == OP_PAGE;
	assign FLASH_MASS_ERASE_O = pulse_active && op == OP_MASS;

	// ----------------------------------------
	// Read data, registered at the address phase
	// ----------------------------------------
	// Offsets that hold nothing, and the write-only command, read as zero
	// Transfer size is not decoded: every access is taken as a whole word
	function [31:0] read_word;
		input [7:0] ofs;
		begin
			case (ofs)
			`FIA_OFS_ADDR_HIGH: read_word = {24'h000000, prog_addr_high_byte};
			`FIA_OFS_ADDR_LOW: read_word = {24'h000000, prog_addr_low_byte};
			`FIA_OFS_READ_BYTE: read_word = {24'h000000, prog_read_byte};
			`FIA_OFS_WRITE_BYTE: read_word = {24'h000000, prog_write_byte};
			`FIA_OFS_PULSE_TIMING: read_word = {25'h0000000, prog_pulse_timing};
			`FIA_OFS_STATUS: read_word = status_word;
			default: read_word = 32'h00000000;
			endcase
		end
	endfunction
	// Sampled at the address phase so the word stands for the whole data phase
	always @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			HRDATA_O <= 32'h00000000;
		end else if (HREADY_I && HSEL_I && HTRANS_I[1] && !HWRITE_I) begin
			HRDATA_O <= read_word(HADDR_I[7:0]);
		end
	end
endmodule
`default_nettype wire

// file: fia_defines.vh
// Register map, reset values and timing constants of the flash programming access block
`ifndef FIA_DEFINES_VH
`define FIA_DEFINES_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define FIA_OFS_ADDR_HIGH 8'h00
`define FIA_OFS_ADDR_LOW 8'h04
`define FIA_OFS_READ_BYTE 8'h08
`define FIA_OFS_WRITE_BYTE 8'h0C
`define FIA_OFS_PULSE_TIMING 8'h10
`define FIA_OFS_COMMAND 8'h14
`define FIA_OFS_STATUS 8'h18
// ----------------------------------------
// Reset values
// ----------------------------------------
`define FIA_RST_ADDR 8'h00
`define FIA_RST_PULSE_TIMING 7'h7B
// ----------------------------------------
// Field positions
// ----------------------------------------
`define FIA_CMD_READ 0
`define FIA_CMD_WRITE 1
`define FIA_CMD_PAGE_ERASE 2
`define FIA_CMD_MASS_ERASE 3
`define FIA_ST_BUSY 0
`define FIA_ST_BOOT_ROM 1
`define FIA_ST_FETCH_BLOCKED 2
`define FIA_ST_ROM_SIZE 16
// ----------------------------------------
// Address mapping and timing
// ----------------------------------------
`define FIA_OPTION_ALIAS 16'hFFFF
`define FIA_OPTION_PHYS 16'h7FFF
`define FIA_BOOT_ROM_BYTES 16'h0400
`define FIA_RESET_VECTOR 16'h0000
`define FIA_PULSE_UNIT 16'h0010
`endif

// file: fia_flash_mdl.sv
// Behavioural flash array facing the block
`timescale 1ns/100ps
`default_nettype none
module fia_flash_mdl #(
	parameter int PAGE_BYTES = 128
) (
	input wire logic clk_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic read_i,
	input wire logic prog_i,
	input wire logic page_i,
	input wire logic mass_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [0:65535];
	// Alias and physical option bytes differ so a missing remap shows
	initial for (int i = 0; i < 65536; i++) mem[i] = 8'(i ^ (i >> 8));
	// Data only under the strobe; otherwise the inverse, never a held value
	assign rdata_o = read_i ? mem[addr_i] : ~mem[addr_i];
	// Program and erase act on every cycle of their pulse
	always @(posedge clk_i) begin
		if (prog_i) mem[addr_i] <= wdata_i;
		if (page_i) for (int i = 0; i < PAGE_BYTES; i++) mem[(addr_i & ~(PAGE_BYTES - 1)) + i] <= 8'hFF;
		if (mass_i) for (int i = 0; i < 65536; i++) mem[i] <= 8'hFF;
	end
endmodule
`default_nettype wire

// file: fia_pulse_timer.v
// Pulse width timer for flash write and erase operations
`timescale 1ns/100ps
`default_nettype none
module fia_pulse_timer #(
	parameter UNIT = 16
) (
	input wire clk_i,
	input wire reset_i,
	input wire start_i,
	input wire [6:0] timing_i,
	output reg active_o,
	output reg done_o
);
	// ----------------------------------------
	// Prescaler and unit counter
	// ----------------------------------------
	reg [15:0] pre;
	reg [6:0] units;
	// Width is (timing+1) units of UNIT clocks, so a zero value still gives a pulse
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pre <= 16'h0000;
			units <= 7'h00;
			active_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i && !active_o) begin
				active_o <= 1'b1;
				pre <= 16'h0000;
				units <= timing_i;
			end else if (active_o) begin
				if (pre == UNIT[15:0] - 16'h0001) begin
					pre <= 16'h0000;
					if (units == 7'h00) begin
						active_o <= 1'b0;
						done_o <= 1'b1;
					end else begin
						units <= units - 7'h01;
					end
				end else begin
					pre <= pre + 16'h0001;
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the flash programming access block
`timescale 1ns/100ps
`default_nettype none
`include "fia_defines.vh"
module testbench;
	localparam int PU = 1;
	logic clk, rst, hsel, hwrite, hready, hresp, boot_opt, fetch_boot, ser_cmd;
	logic boot_rom, blocked, mon, frd, fprog, fpage, fmass;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rd, xs_state, v;
	logic [15:0] vec, faddr, a, pa;
	logic [7:0] fwd, frdata;
	logic [7:0] ofs [4] = '{`FIA_OFS_ADDR_HIGH, `FIA_OFS_ADDR_LOW, `FIA_OFS_WRITE_BYTE, `FIA_OFS_PULSE_TIMING};
	int error_cnt, cmp_count, n;
	fia_core #(.PULSE_UNIT(PU)) u_dut (.CLK_I(clk), .RESET_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
		.HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'b010), .HWDATA_I(hwdata), .HREADY_I(hready),
		.HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .BOOT_OPTION_I(boot_opt),
		.FETCH_FROM_BOOT_I(fetch_boot), .SERIAL_CMD_I(ser_cmd), .BOOT_FROM_ROM_O(boot_rom),
		.RESET_VECTOR_O(vec), .FETCH_BLOCKED_O(blocked), .SERIAL_MONITOR_O(mon), .FLASH_ADDR_O(faddr),
		.FLASH_WDATA_O(fwd), .FLASH_RDATA_I(frdata), .FLASH_READ_O(frd), .FLASH_PROG_O(fprog),
		.FLASH_PAGE_ERASE_O(fpage), .FLASH_MASS_ERASE_O(fmass));
	fia_flash_mdl u_flash (.clk_i(clk), .addr_i(faddr), .wdata_i(fwd), .read_i(frd), .prog_i(fprog),
		.page_i(fpage), .mass_i(fmass), .rdata_o(frdata));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs();
		xs_state ^= xs_state << 13;
		xs_state ^= xs_state >> 17;
		xs_state ^= xs_state << 5;
		return xs_state;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Single AHB-Lite transfer; read data kept in rd
	task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h0, ad};
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
		bus(1'b0, ad, 32'h0);
		chk(rd, e);
	endtask
	task automatic setup(input logic [15:0] ad, input logic [7:0] d, input logic [6:0] t);
		bus(1'b1, `FIA_OFS_ADDR_HIGH, {24'h0, ad[15:8]});
		bus(1'b1, `FIA_OFS_ADDR_LOW, {24'h0, ad[7:0]});
		bus(1'b1, `FIA_OFS_WRITE_BYTE, {24'h0, d});
		bus(1'b1, `FIA_OFS_PULSE_TIMING, {25'h0, t});
	endtask
	// Read command; result lands one cycle after the command
	task automatic fread(input logic [15:0] ad);
		setup(ad, 8'h00, 7'h01);
		bus(1'b1, `FIA_OFS_COMMAND, 32'h1);
		repeat (3) @(posedge clk);
	endtask
	// Count cycles a selected pulse stands, then let busy drop
	task automatic width(input logic [2:0] sel);
		n = 0;
		repeat (4) if (({fmass, fpage, fprog} & sel) == 3'b000) @(posedge clk);
		while (({fmass, fpage, fprog} & sel) != 3'b000) begin
			n++;
			@(posedge clk);
		end
		repeat (2) @(posedge clk);
	endtask
	task automatic reset_dut(input logic opt);
		rst <= 1'b1;
		boot_opt <= opt;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		// The strap is taken at the first edge and shows only after it
		repeat (2) @(posedge clk);
	endtask
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// ----------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// A hang in a handshake wait ends here
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		print_verdict();
	end
	initial begin
		{rst, hsel, hwrite, ser_cmd, fetch_boot, boot_opt} = 6'b100001;
		htrans = 2'b00; haddr = 32'h0; hwdata = 32'h0; xs_state = 32'd63;
		error_cnt = 0; cmp_count = 0; n = 0;
		reset_dut(1'b1);
		chk(32'(boot_rom), 32'h0);
		chk(32'(vec), 32'h0);
		rchk(`FIA_OFS_ADDR_HIGH, 32'h0);
		rchk(`FIA_OFS_ADDR_LOW, 32'h0);
		rchk(`FIA_OFS_PULSE_TIMING, 32'h7B);
		rchk(8'h1C, 32'h0);
		rchk(`FIA_OFS_STATUS, {`FIA_BOOT_ROM_BYTES, 16'h0000});
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			v = xs();
			fetch_boot <= v[9];
			for (int j = 0; j < 4; j++) begin
				bus(1'b1, ofs[j], v >> (8 * j));
				rchk(ofs[j], (v >> (8 * j)) & (j == 3 ? 32'h7F : 32'hFF));
			end
		end
		fread(16'hFFFF);
		rchk(`FIA_OFS_READ_BYTE, 32'h80);
		for (int k = 1; k < 4; k++) begin
			v = xs();
			a = (k == 3) ? 16'h0000 : (k == 2) ? {v[15:7], 7'h00} : {v[15:1], 1'b0};
			if (k == 1) pa = a;
			setup(a, v[23:16], {4'h0, v[26:24]});
			bus(1'b1, `FIA_OFS_COMMAND, 32'h1 << k);
			width(3'b001 << (k - 1));
			chk(32'(n), 32'((v[26:24] + 1) * PU));
			chk(32'(faddr), 32'(a));
			if (k == 2) begin
				fread(a);
				rchk(`FIA_OFS_READ_BYTE, 32'hFF);
			end
			if (k == 1) begin
				fread(pa);
				rchk(`FIA_OFS_READ_BYTE, {24'h0, v[23:16]});
			end
		end
		fread(pa);
		rchk(`FIA_OFS_READ_BYTE, 32'hFF);
		$display("test operations done");
		reset_dut(1'b0);
		ser_cmd <= 1'b1;
		fetch_boot <= 1'b0;
		repeat (2) @(posedge clk);
		chk(32'(boot_rom), 32'h1);
		chk(32'(mon), 32'h1);
		// Option programmed to one: no effect until the next reset
		boot_opt <= 1'b1;
		setup(16'h0123, 8'h5C, 7'd20);
		bus(1'b1, `FIA_OFS_COMMAND, 32'h2);
		bus(1'b1, `FIA_OFS_ADDR_LOW, 32'h33);
		chk(32'(hresp), 32'h0);
		rchk(`FIA_OFS_STATUS, {`FIA_BOOT_ROM_BYTES, 16'h0007});
		chk(32'(blocked), 32'h1);
		fetch_boot <= 1'b1;
		rchk(`FIA_OFS_STATUS, {`FIA_BOOT_ROM_BYTES, 16'h0003});
		chk(32'(blocked), 32'h0);
		width(3'b001);
		rchk(`FIA_OFS_ADDR_LOW, 32'h23);
		chk(32'(boot_rom), 32'h1);
		$display("test boot rom done");
		reset_dut(1'b1);
		chk(32'(boot_rom), 32'h0);
		chk(32'(mon), 32'h0);
		$display("test return to flash done");
		print_verdict();
	end
endmodule
`default_nettype wire
